// ---- inc/hbs_map.svh ----
// Summary of operation
// - Release brake, enable after full release delay
// - Extra release delay: 0 to 4400 ms
// - On disable, brake applies, current held
// - Extra apply delay: 0 to 1000 ms
// - Delay writes refused while power stage enabled
// - New delays apply at next enable only
// - Torque off cuts current, skips apply delay
// - Brake holds position while stage disabled
// - Brake check moves while button held
// - Brake check starts only when ready
`ifndef HBS_MAP_SVH
`define HBS_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets and reset values
`define HBS_ADDR_W 16
`define HBS_DATA_W 16
`define HBS_OFS_EXTRA_RELEASE 16'h050e
`define HBS_OFS_EXTRA_APPLY 16'h0510
`define HBS_RST_EXTRA_RELEASE 16'h0000
`define HBS_RST_EXTRA_APPLY 16'h0000
`define HBS_MAX_EXTRA_RELEASE 16'h1130
`define HBS_MAX_EXTRA_APPLY 16'h03e8

////////////////////////////////////////////////////////////////////////////////
// Timing base
`define HBS_CLK_PERIOD_NS 8
`define HBS_MS_TIME_NS 1000000
`define HBS_MS_CYCLES ((`HBS_MS_TIME_NS + `HBS_CLK_PERIOD_NS - 1) / `HBS_CLK_PERIOD_NS)
`define HBS_TICK_W 17
`define HBS_CNT_W 17

`endif

// ---- inc/hbs_pkg.sv ----
`default_nettype none

package hbs_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        HBS_ST_READY = 3'b000,
        HBS_ST_RELEASE = 3'b001,
        HBS_ST_ENABLED = 3'b010,
        HBS_ST_APPLY = 3'b011,
        HBS_ST_CHECK = 3'b100,
        HBS_ST_TRIP = 3'b101
    } hbs_state_e;

    typedef logic [15:0] hbs_word_t;

endpackage : hbs_pkg

`default_nettype wire

// ---- rtl/hbs_ms_tick.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "hbs_map.svh"

module hbs_ms_tick #(
    parameter int unsigned MS_CYCLES = `HBS_MS_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic restart,
    output logic tick
);

    logic [`HBS_TICK_W-1:0] div_ff;
    logic [`HBS_TICK_W-1:0] nxt_div;
    logic tick_ff;
    wire logic at_end;

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler; restart realigns so a delay is never cut short
    assign at_end = (div_ff == `HBS_TICK_W'(MS_CYCLES - 1));
    assign nxt_div = (restart || at_end) ? '0 : div_ff + `HBS_TICK_W'(1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else if (clk_en) begin
            div_ff <= nxt_div;
            tick_ff <= at_end && !restart;
        end
    end

    assign tick = tick_ff;

endmodule : hbs_ms_tick

`default_nettype wire

// ---- rtl/hbs_delay_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "hbs_map.svh"

module hbs_delay_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [`HBS_CNT_W-1:0] load_val,
    input wire logic tick,
    output logic done
);

    logic [`HBS_CNT_W-1:0] cnt_ff;
    logic [`HBS_CNT_W-1:0] nxt_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Countdown of whole milliseconds, stops at zero
    assign nxt_cnt = load ? load_val :
                     (tick && cnt_ff != '0) ? cnt_ff - `HBS_CNT_W'(1) : cnt_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= '0;
        end else if (clk_en) begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign done = (cnt_ff == '0);

endmodule : hbs_delay_timer

`default_nettype wire

// ---- rtl/hbs_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "hbs_map.svh"

module hbs_top
    import hbs_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `HBS_MS_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Operator and controller requests
    input wire logic enable_req,
    input wire logic check_start,
    input wire logic nav_button,
    input wire logic esc_key,
    input wire logic brake_params_set,
    // Torque off channels, high while energised
    input wire logic torque_off_channel_a,
    input wire logic torque_off_channel_b,
    // Motor nameplate delays in ms
    input wire logic [15:0] motor_release_delay,
    input wire logic [15:0] motor_apply_delay,
    // Parameter access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`HBS_ADDR_W-1:0] reg_addr,
    input wire logic [`HBS_DATA_W-1:0] reg_wdata,
    output logic [`HBS_DATA_W-1:0] reg_rdata,
    output logic reg_ack,
    output logic reg_err,
    // Power stage and brake
    output logic brake_release,
    output logic motor_current_on,
    output logic op_enabled,
    output logic ready_to_switch_on,
    output logic check_active,
    output logic motor_move,
    output logic torque_off_active
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    hbs_state_e state_ff;
    hbs_state_e nxt_state;
    hbs_word_t extra_release_delay_ff;
    hbs_word_t extra_apply_delay_ff;
    hbs_word_t nxt_extra_release;
    hbs_word_t nxt_extra_apply;
    hbs_word_t act_apply_ff;
    hbs_word_t nxt_act_apply;
    logic [`HBS_DATA_W-1:0] reg_rdata_ff;
    logic [`HBS_DATA_W-1:0] nxt_rdata;
    logic reg_ack_ff;
    logic reg_err_ff;
    logic nxt_err;
    logic brake_release_ff;
    logic motor_current_ff;
    logic op_enabled_ff;
    logic ready_ff;
    logic check_active_ff;
    logic motor_move_ff;
    logic torque_off_ff;
    logic nxt_brake_release;
    logic nxt_motor_current;
    logic nxt_op_enabled;
    logic nxt_ready;
    logic nxt_move;
    logic tmr_load;
    logic [`HBS_CNT_W-1:0] tmr_val;
    wire logic ms_tick;
    wire logic tmr_done;

    ////////////////////////////////////////////////////////////////////////////
    // Torque off status and readiness
    wire logic sto_trip = !torque_off_channel_a || !torque_off_channel_b;
    wire logic in_ready = (state_ff == HBS_ST_READY);
    wire logic stage_off = in_ready || (state_ff == HBS_ST_TRIP);
    // Either channel dropping trips; both must return before leaving
    wire logic sto_ok = !sto_trip;

    ////////////////////////////////////////////////////////////////////////////
    // Delay sums, widened so the largest sum cannot wrap
    wire logic [`HBS_CNT_W-1:0] release_sum = {1'b0, motor_release_delay} + {1'b0, extra_release_delay_ff};
    wire logic [`HBS_CNT_W-1:0] apply_sum = {1'b0, motor_apply_delay} + {1'b0, act_apply_ff};

    ////////////////////////////////////////////////////////////////////////////
    // Request decode
    wire logic start_enable = in_ready && enable_req && sto_ok;
    wire logic start_check = in_ready && check_start && brake_params_set && sto_ok && !enable_req;
    wire logic leave_check = (state_ff == HBS_ST_CHECK) && esc_key;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state; trip overrides every other request
    always_comb begin
        nxt_state = state_ff;
        tmr_load = 1'b0;
        tmr_val = release_sum;
        if (sto_trip) begin
            nxt_state = HBS_ST_TRIP;
        end else begin
            case (state_ff)
                HBS_ST_READY: begin
                    if (start_enable) begin
                        nxt_state = HBS_ST_RELEASE;
                        tmr_load = 1'b1;
                        tmr_val = release_sum;
                    end else if (start_check) begin
                        nxt_state = HBS_ST_CHECK;
                    end
                end
                HBS_ST_RELEASE: begin
                    if (!enable_req) begin
                        nxt_state = HBS_ST_APPLY;
                        tmr_load = 1'b1;
                        tmr_val = apply_sum;
                    end else if (tmr_done) begin
                        nxt_state = HBS_ST_ENABLED;
                    end
                end
                HBS_ST_ENABLED: begin
                    if (!enable_req) begin
                        nxt_state = HBS_ST_APPLY;
                        tmr_load = 1'b1;
                        tmr_val = apply_sum;
                    end
                end
                HBS_ST_APPLY: begin
                    if (tmr_done) begin
                        nxt_state = HBS_ST_READY;
                    end
                end
                HBS_ST_CHECK: begin
                    if (leave_check) begin
                        nxt_state = HBS_ST_APPLY;
                        tmr_load = 1'b1;
                        tmr_val = apply_sum;
                    end
                end
                HBS_ST_TRIP: begin
                    // No restart while a request is still standing
                    if (!enable_req) begin
                        nxt_state = HBS_ST_READY;
                    end
                end
                default: begin
                    nxt_state = HBS_ST_TRIP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output decode from the next state, so outputs are plain flops
    always_comb begin
        nxt_brake_release = 1'b0;
        nxt_motor_current = 1'b0;
        nxt_op_enabled = 1'b0;
        nxt_move = 1'b0;
        case (nxt_state)
            HBS_ST_RELEASE: begin
                nxt_brake_release = 1'b1;
                nxt_motor_current = 1'b1;
            end
            HBS_ST_ENABLED: begin
                nxt_brake_release = 1'b1;
                nxt_motor_current = 1'b1;
                nxt_op_enabled = 1'b1;
            end
            HBS_ST_APPLY: begin
                nxt_motor_current = 1'b1;
            end
            HBS_ST_CHECK: begin
                nxt_motor_current = 1'b1;
                nxt_brake_release = nav_button && !esc_key;
                nxt_move = nav_button && !esc_key;
            end
            default: begin
                // Ready and trip: no current, brake holds the load
                nxt_brake_release = 1'b0;
                nxt_motor_current = 1'b0;
            end
        endcase
    end

    assign nxt_ready = (nxt_state == HBS_ST_READY) && sto_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Parameter write checks: range and power stage state
    wire logic hit_release = (reg_addr == `HBS_OFS_EXTRA_RELEASE);
    wire logic hit_apply = (reg_addr == `HBS_OFS_EXTRA_APPLY);
    wire logic hit_any = hit_release || hit_apply;
    // Unsigned compare also refuses negative values of the signed word
    wire logic rel_in_range = (reg_wdata <= `HBS_MAX_EXTRA_RELEASE);
    wire logic app_in_range = (reg_wdata <= `HBS_MAX_EXTRA_APPLY);
    wire logic wr_ok_state = stage_off && (nxt_state == HBS_ST_READY || nxt_state == HBS_ST_TRIP);
    wire logic wr_release = reg_wr && hit_release && rel_in_range && wr_ok_state;
    wire logic wr_apply = reg_wr && hit_apply && app_in_range && wr_ok_state;
    wire logic wr_refused = reg_wr && !(wr_release || wr_apply);

    assign nxt_extra_release = wr_release ? reg_wdata : extra_release_delay_ff;
    assign nxt_extra_apply = wr_apply ? reg_wdata : extra_apply_delay_ff;
    assign nxt_err = wr_refused || (reg_rd && !hit_any);

    // Apply figure frozen at enable, so a later edit waits for the next enable
    assign nxt_act_apply = (tmr_load && nxt_state == HBS_ST_RELEASE) ? extra_apply_delay_ff : act_apply_ff;

    // Read mux, zero for unmapped offsets
    assign nxt_rdata = !reg_rd ? reg_rdata_ff :
                       hit_release ? extra_release_delay_ff :
                       hit_apply ? extra_apply_delay_ff : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Shared millisecond base and one countdown for both delays
    hbs_ms_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .restart(tmr_load),
        .tick(ms_tick)
    );

    hbs_delay_timer u_timer (
        .clk(clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .load(tmr_load),
        .load_val(tmr_val),
        .tick(ms_tick),
        .done(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State and parameter registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= HBS_ST_READY;
            extra_release_delay_ff <= `HBS_RST_EXTRA_RELEASE;
            extra_apply_delay_ff <= `HBS_RST_EXTRA_APPLY;
            act_apply_ff <= `HBS_RST_EXTRA_APPLY;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            extra_release_delay_ff <= nxt_extra_release;
            extra_apply_delay_ff <= nxt_extra_apply;
            act_apply_ff <= nxt_act_apply;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access answer flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_ff <= 16'h0000;
            reg_ack_ff <= 1'b0;
            reg_err_ff <= 1'b0;
        end else if (clk_en) begin
            reg_rdata_ff <= nxt_rdata;
            reg_ack_ff <= reg_wr || reg_rd;
            reg_err_ff <= nxt_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power stage and brake drive flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            brake_release_ff <= 1'b0;
            motor_current_ff <= 1'b0;
            op_enabled_ff <= 1'b0;
            ready_ff <= 1'b0;
            check_active_ff <= 1'b0;
            motor_move_ff <= 1'b0;
            torque_off_ff <= 1'b0;
        end else if (clk_en) begin
            brake_release_ff <= nxt_brake_release;
            motor_current_ff <= nxt_motor_current;
            op_enabled_ff <= nxt_op_enabled;
            ready_ff <= nxt_ready;
            check_active_ff <= (nxt_state == HBS_ST_CHECK);
            motor_move_ff <= nxt_move;
            torque_off_ff <= sto_trip;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port drive
    assign reg_rdata = reg_rdata_ff;
    assign reg_ack = reg_ack_ff;
    assign reg_err = reg_err_ff;
    assign brake_release = brake_release_ff;
    assign motor_current_on = motor_current_ff;
    assign op_enabled = op_enabled_ff;
    assign ready_to_switch_on = ready_ff;
    assign check_active = check_active_ff;
    assign motor_move = motor_move_ff;
    assign torque_off_active = torque_off_ff;

endmodule : hbs_top

`default_nettype wire

// ---- dv/hbs_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "hbs_map.svh"

module hbs_monitor #(
    parameter int unsigned MS_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic enable_req,
    input wire logic nav_button,
    input wire logic brake_params_set,
    input wire logic torque_off_channel_a,
    input wire logic torque_off_channel_b,
    input wire logic [15:0] motor_release_delay,
    input wire logic [15:0] motor_apply_delay,
    input wire logic reg_wr,
    input wire logic [`HBS_ADDR_W-1:0] reg_addr,
    input wire logic [`HBS_DATA_W-1:0] reg_wdata,
    input wire logic reg_err,
    input wire logic brake_release,
    input wire logic motor_current_on,
    input wire logic op_enabled,
    input wire logic ready_to_switch_on,
    input wire logic check_active,
    input wire logic motor_move
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Either channel low means a trip
    wire logic trip = !torque_off_channel_a || !torque_off_channel_b;
    logic [31:0] rel_cnt_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Cycles with brake released before operation enabled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rel_cnt_ff <= 32'h0000_0000;
        end else if (!brake_release || op_enabled) begin
            rel_cnt_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            rel_cnt_ff <= rel_cnt_ff + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Disable request seen while running normally
    sequence seq_off;
        op_enabled && !enable_req && !trip && clk_en;
    endsequence
    sequence seq_wr;
        reg_wr && clk_en;
    endsequence

    chk_rel_range: assert property (seq_wr ##0 (reg_addr == `HBS_OFS_EXTRA_RELEASE &&
        reg_wdata > `HBS_MAX_EXTRA_RELEASE) |=> reg_err) else $error("release limit not refused");
    chk_app_range: assert property (seq_wr ##0 (reg_addr == `HBS_OFS_EXTRA_APPLY &&
        reg_wdata > `HBS_MAX_EXTRA_APPLY) |=> reg_err) else $error("apply limit not refused");
    chk_locked_wr: assert property (seq_wr ##0 op_enabled |=> reg_err)
        else $error("write accepted while enabled");
    chk_trip_cut: assert property (trip && motor_current_on && clk_en |=> !motor_current_on && !brake_release)
        else $error("trip kept current");
    chk_brake_off: assert property (seq_off |=> !brake_release && !op_enabled)
        else $error("brake not applied on disable");
    chk_apply_hold: assert property (seq_off ##0 motor_apply_delay != 16'h0000 |=> motor_current_on)
        else $error("current dropped at disable");
    chk_rel_wait: assert property ($rose(op_enabled) |-> brake_release &&
        rel_cnt_ff >= motor_release_delay * MS_CYCLES) else $error("enabled too early");
    chk_move_follow: assert property (check_active && !nav_button && clk_en |=> !motor_move)
        else $error("moved without button");
    chk_check_gate: assert property ($rose(check_active) |->
        $past(ready_to_switch_on) && $past(brake_params_set)) else $error("check began when not ready");
endmodule : hbs_monitor

bind hbs_top hbs_monitor #(.MS_CYCLES(MS_CYCLES)) mon (.clk, .rstn, .clk_en, .enable_req, .nav_button,
    .brake_params_set, .torque_off_channel_a, .torque_off_channel_b, .motor_release_delay,
    .motor_apply_delay, .reg_wr, .reg_addr, .reg_wdata, .reg_err, .brake_release, .motor_current_on,
    .op_enabled, .ready_to_switch_on, .check_active, .motor_move);

`default_nettype wire

// ---- dv/hbs_motor_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module hbs_motor_model #(
    parameter int unsigned REL_MS = 2,
    parameter int unsigned APP_MS = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic trip_cmd,
    input wire logic brake_release,
    input wire logic motor_current_on,
    output logic [15:0] motor_release_delay,
    output logic [15:0] motor_apply_delay,
    output logic torque_off_channel_a,
    output logic torque_off_channel_b,
    output logic drift
);
    // Nameplate delays of this motor type
    assign motor_release_delay = 16'(REL_MS);
    assign motor_apply_delay = 16'(APP_MS);

    ////////////////////////////////////////////////////////////////////////////////
    // Both channels switch on one edge; skew would look like a wiring fault
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            torque_off_channel_a <= 1'b1;
            torque_off_channel_b <= 1'b1;
            drift <= 1'b0;
        end else begin
            torque_off_channel_a <= !trip_cmd;
            torque_off_channel_b <= !trip_cmd;
            // Hanging load slips if brake open and no torque
            drift <= drift || (brake_release && !motor_current_on);
        end
    end
endmodule : hbs_motor_model

`default_nettype wire

// ---- dv/hbs_top_bench.sv ----
`timescale 1ns/100ps
`default_nettype none

module hbs_top_bench;
    localparam int MS = 4;
    localparam int REL = 2;
    localparam int APP = 1;
    logic clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, enable_req = 1'b0, check_start = 1'b0;
    logic nav_button = 1'b0, esc_key = 1'b0, brake_params_set = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic trip_cmd = 1'b0;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000;
    wire logic [15:0] reg_rdata, mrel, mapp;
    wire logic reg_ack, reg_err, brake_release, motor_current_on, op_enabled, rdy, check_active;
    wire logic motor_move, toa, cha, chb, drift;
    int error_cnt = 0, comparisons = 0;

    always #4 clk = ~clk;

    hbs_top #(.MS_CYCLES(MS)) uut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .enable_req(enable_req),
        .check_start(check_start), .nav_button(nav_button), .esc_key(esc_key),
        .brake_params_set(brake_params_set), .torque_off_channel_a(cha), .torque_off_channel_b(chb),
        .motor_release_delay(mrel), .motor_apply_delay(mapp), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .brake_release(brake_release), .motor_current_on(motor_current_on),
        .op_enabled(op_enabled), .ready_to_switch_on(rdy), .check_active(check_active),
        .motor_move(motor_move), .torque_off_active(toa));

    hbs_motor_model #(.REL_MS(REL), .APP_MS(APP)) motor (.clk(clk), .rstn(rstn), .trip_cmd(trip_cmd),
        .brake_release(brake_release), .motor_current_on(motor_current_on), .motor_release_delay(mrel),
        .motor_apply_delay(mapp), .torque_off_channel_a(cha), .torque_off_channel_b(chb), .drift(drift));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and closing helpers
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        comparisons++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("mismatch at %0t: %s took %0d not %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : chk_rng

    // Whole ms of delay expressed in clock cycles
    function automatic int exp_cyc(input int ms);
        return ms * MS;
    endfunction : exp_cyc

    function automatic logic sig(input int k);
        case (k)
            0: return op_enabled;
            1: return motor_current_on;
            2: return rdy;
            default: return check_active;
        endcase
    endfunction : sig

    // Bounded wait; a hang ends the run as a failure
    task automatic wait_for(input int k, input logic v, output int n);
        n = 0;
        // Step off the edge so a flop launched there is settled
        #1;
        while (sig(k) !== v && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (sig(k) !== v) begin
            error_cnt++;
            $display("mismatch at %0t: wait timed out", $time);
            test_done();
        end
    endtask : wait_for

    // One register access; strobe held until the taking edge
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic e,
        output logic [15:0] q);
        int n = 0;
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        while (reg_ack !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(reg_ack, 1'b1, "ack");
        if (reg_ack !== 1'b1) begin
            test_done();
        end
        e = reg_err;
        q = reg_rdata;
    endtask : acc

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        logic e;
        logic [15:0] q, r, a;
        n = $urandom(32'hfae2);
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        acc(1'b0, 16'h050e, 16'h0000, e, q);
        chk(q, 16'h0000, "release reset");
        acc(1'b0, 16'h0510, 16'h0000, e, q);
        chk(q, 16'h0000, "apply reset");
        acc(1'b0, 16'h0512, 16'h0000, e, q);
        chk(e, 1'b1, "unmapped read");
        acc(1'b1, 16'h050e, 16'h1131, e, q);
        chk(e, 1'b1, "release over");
        acc(1'b1, 16'h050e, 16'h1130, e, q);
        chk(e, 1'b0, "release max");
        acc(1'b1, 16'h0510, 16'h03e9, e, q);
        chk(e, 1'b1, "apply over");
        acc(1'b1, 16'h0510, 16'hffff, e, q);
        chk(e, 1'b1, "apply negative");
        acc(1'b1, 16'h0510, 16'h03e8, e, q);
        acc(1'b0, 16'h0510, 16'h0000, e, q);
        chk(q, 16'h03e8, "apply max");
        $display("test registers done");
        // Frozen clock enable must hold off a standing enable request
        @(posedge clk);
        clk_en <= 1'b0;
        enable_req <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({motor_current_on, rdy}, 2'b01, "frozen by clock enable");
        @(posedge clk);
        enable_req <= 1'b0;
        clk_en <= 1'b1;
        // New delays each round, first round with zero extra release
        for (int i = 0; i < 3; i++) begin
            r = (i == 0) ? 16'h0000 : 16'($urandom % 4);
            a = 16'($urandom % 3);
            acc(1'b1, 16'h050e, r, e, q);
            acc(1'b1, 16'h0510, a, e, q);
            @(posedge clk);
            enable_req <= 1'b1;
            wait_for(1, 1'b1, n);
            wait_for(0, 1'b1, n);
            chk_rng(n, exp_cyc(REL + r), exp_cyc(REL + r) + 4, "release wait");
            acc(1'b1, 16'h050e, 16'h0007, e, q);
            chk(e, 1'b1, "write while enabled");
            acc(1'b0, 16'h050e, 16'h0000, e, q);
            chk(q, r, "value kept");
            @(posedge clk);
            enable_req <= 1'b0;
            @(posedge clk);
            #1;
            chk({brake_release, motor_current_on}, 2'b01, "brake on current held");
            wait_for(1, 1'b0, n);
            chk_rng(n, exp_cyc(APP + a) - 1, exp_cyc(APP + a) + 4, "apply wait");
            wait_for(2, 1'b1, n);
        end
        $display("test enable cycles done");
        @(posedge clk);
        enable_req <= 1'b1;
        wait_for(0, 1'b1, n);
        @(posedge clk);
        trip_cmd <= 1'b1;
        wait_for(1, 1'b0, n);
        chk_rng(n, 0, 3, "trip cut");
        chk({toa, rdy, brake_release, op_enabled}, 4'b1000, "trip state");
        // Enable dropped before channels return: no restart
        @(posedge clk);
        enable_req <= 1'b0;
        trip_cmd <= 1'b0;
        wait_for(2, 1'b1, n);
        $display("test torque off done");
        @(posedge clk);
        check_start <= 1'b1;
        @(posedge clk);
        check_start <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(check_active, 1'b0, "check needs params");
        @(posedge clk);
        brake_params_set <= 1'b1;
        check_start <= 1'b1;
        @(posedge clk);
        check_start <= 1'b0;
        wait_for(3, 1'b1, n);
        chk(motor_move, 1'b0, "idle in check");
        @(posedge clk);
        nav_button <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({motor_move, brake_release}, 2'b11, "held moves");
        @(posedge clk);
        nav_button <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({motor_move, brake_release}, 2'b00, "released stops");
        @(posedge clk);
        esc_key <= 1'b1;
        @(posedge clk);
        esc_key <= 1'b0;
        wait_for(3, 1'b0, n);
        wait_for(2, 1'b1, n);
        chk(drift, 1'b0, "load held");
        $display("test brake check done");
        test_done();
    end
endmodule : hbs_top_bench

`default_nettype wire
